//--- hdl/cfa_defs.svh
/*
 * register offsets, field positions and reset values for the cpu fifo
 * access port and for the controller's own apb registers.
 * assumes byte addresses; included by bare name.
 */
`ifndef CFA_DEFS_SVH
`define CFA_DEFS_SVH

// ==========================================================
// device cpu port map (byte addresses, 16-bit port words)
`define CFA_OFS_READ_LANE_LOW    8'h20
`define CFA_OFS_READ_LANE_HIGH   8'h21
`define CFA_OFS_WRITE_LANE_LOW   8'h22
`define CFA_OFS_WRITE_LANE_HIGH  8'h23
`define CFA_OFS_READABLE_COUNT   8'h24
`define CFA_OFS_FREE_COUNT       8'h26
`define CFA_OFS_SINGLE_BYTE_READ 8'h28

// ==========================================================
// count register fields
`define CFA_COUNT_W              13
`define CFA_VALID_BIT            15
`define CFA_COUNT_RESET          16'h0000

// ==========================================================
// device defaults
`define CFA_AREAS                6
`define CFA_AREA_BYTES           64
`define CFA_STAGE_DEPTH          8

// ==========================================================
// controller apb map
`define CFA_APB_CMD              12'h000
`define CFA_APB_WDATA            12'h004
`define CFA_APB_RESULT           12'h008
`define CFA_APB_STATUS           12'h00C
`define CFA_RES_LANES_LSB        16
`define CFA_RES_REFUSED_BIT      18

`endif

//--- hdl/cfa_pkg.sv
/*
 * shared types for the cpu fifo access port and its controller.
 * assumes nothing beyond a systemverilog compiler.
 */
package cfa_pkg;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_READ,
        OP_WRITE,
        OP_BYTE
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CHECK,
        ST_CHECK_WAIT,
        ST_MOVE,
        ST_MOVE_WAIT,
        ST_SETTLE
    } host_state_t;
endpackage

//--- hdl/cfa_link.sv
/*
 * cpu interface between the fifo access port and its controller.
 * assumes both ends run on the same clk_sys; one request per ack.
 */
interface cfa_link;
    logic        req;
    logic        wr;
    logic [7:0]  addr;
    logic [1:0]  be;
    logic [15:0] wdata;
    logic        ack;
    logic [15:0] rdata;
    logic [1:0]  lanes;

    modport dev (
        input  req,
        input  wr,
        input  addr,
        input  be,
        input  wdata,
        output ack,
        output rdata,
        output lanes
    );

    modport host (
        output req,
        output wr,
        output addr,
        output be,
        output wdata,
        input  ack,
        input  rdata,
        input  lanes
    );
endinterface

//--- hdl/cfa_device.sv
/*
 * fifo access port of the controller: six byte fifo areas, a cpu port
 * with two read lanes, two write lanes, count registers and a byte read,
 * plus a staging fifo that feeds the areas from the usb side.
 * assumes join selects are held stable by the area join logic outside.
 */
`include "cfa_defs.svh"

// ==========================================================
// staging fifo
module cfa_stage_fifo #(
    parameter int W = 11,
    parameter int D = `CFA_STAGE_DEPTH
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [PW:0]  wp_q, wp_d;
    logic [PW:0]  rp_q, rp_d;
    logic         push;
    logic         pop;

    always_comb begin
        in_ready  = (wp_q - rp_q) != (PW+1)'(D);
        out_valid = wp_q != rp_q;
        out_data  = mem[rp_q[PW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wp_d      = wp_q + (PW+1)'(push);
        rp_d      = rp_q + (PW+1)'(pop);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_q[PW-1:0]] <= in_data;
        end
    end
endmodule

// ==========================================================
// fifo access port
module cfa_device #(
    parameter int AREAS = `CFA_AREAS,
    parameter int DEPTH = `CFA_AREA_BYTES
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    cfa_link.dev            cpu,
    input  wire logic [2:0] cpu_read_join_select,
    input  wire logic [2:0] cpu_write_join_select,
    input  wire logic       fill_valid,
    output logic            fill_ready,
    input  wire logic [2:0] fill_area,
    input  wire logic [7:0] fill_data,
    input  wire logic [2:0] drain_area,
    output logic            drain_valid,
    input  wire logic       drain_ready,
    output logic [7:0]      drain_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int MW = $clog2(AREAS * DEPTH);

    logic [7:0]  mem [AREAS * DEPTH];
    logic [AW-1:0] rp_q [AREAS];
    logic [AW-1:0] rp_d [AREAS];
    logic [AW-1:0] wp_q [AREAS];
    logic [AW-1:0] wp_d [AREAS];
    logic [AW:0]   cnt_q [AREAS];
    logic [AW:0]   cnt_d [AREAS];
    logic          ack_q, ack_d;
    logic [15:0]   rdata_q, rdata_d;
    logic [1:0]    lanes_q, lanes_d;

    logic          rd_ok, wr_ok, fa_ok, da_ok;
    logic [2:0]    ra, wa, fa, da;
    logic [AW:0]   avail, free;
    logic [7:0]    rb0, rb1, wb0, wb1;
    logic [1:0]    nrd, nwr, push_n, pop_n;
    logic          fo_valid, fo_ready, fpush, dpop;
    logic [10:0]   fo_word;

    function automatic logic [MW-1:0] idx(input logic [2:0] a, input logic [AW-1:0] p);
        return MW'(int'(a) * DEPTH + int'(p));
    endfunction

    function automatic logic [1:0] lanes_of(input logic [1:0] be);
        return 2'(be[0]) + 2'(be[1]);
    endfunction

    function automatic logic [1:0] take(input logic [1:0] want, input logic [AW:0] have);
        return (have >= (AW+1)'(want)) ? want : have[1:0];
    endfunction

    cfa_stage_fifo #(
        .W (11),
        .D (`CFA_STAGE_DEPTH)
    ) u_stage (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (fill_valid),
        .in_ready  (fill_ready),
        .in_data   ({fill_area, fill_data}),
        .out_valid (fo_valid),
        .out_ready (fo_ready),
        .out_data  (fo_word)
    );

    // ==========================================================
    // cpu port decode and next state
    always_comb begin
        rd_ok   = cpu_read_join_select < 3'(AREAS);
        wr_ok   = cpu_write_join_select < 3'(AREAS);
        ra      = rd_ok ? cpu_read_join_select : 3'h0;
        wa      = wr_ok ? cpu_write_join_select : 3'h0;
        avail   = rd_ok ? cnt_q[ra] : '0;
        free    = wr_ok ? (AW+1)'(DEPTH) - cnt_q[wa] : '0;
        rb0     = mem[idx(ra, rp_q[ra])];
        rb1     = mem[idx(ra, AW'(rp_q[ra] + 1'b1))];
        wb0     = (cpu.be == 2'h2) ? cpu.wdata[15:8] : cpu.wdata[7:0];
        wb1     = cpu.wdata[15:8];
        nrd     = 2'h0;
        nwr     = 2'h0;
        ack_d   = cpu.req;
        rdata_d = 16'h0000;
        lanes_d = 2'h0;
        if (cpu.req) begin
            unique case ({cpu.addr[7:1], 1'b0})
                `CFA_OFS_READ_LANE_LOW: begin
                    if (!cpu.wr) begin
                        nrd = take(lanes_of(cpu.be), avail);
                        if (cpu.be == 2'h2) begin
                            rdata_d[15:8] = rb0;
                            lanes_d       = (nrd != 2'h0) ? 2'h2 : 2'h0;
                        end else begin
                            rdata_d = {(nrd == 2'h2) ? rb1 : 8'h00, (nrd != 2'h0) ? rb0 : 8'h00};
                            lanes_d = {nrd == 2'h2, nrd != 2'h0};
                        end
                    end
                end
                `CFA_OFS_WRITE_LANE_LOW: begin
                    if (cpu.wr) begin
                        nwr     = take(lanes_of(cpu.be), free);
                        lanes_d = (nwr == 2'h2) ? 2'h3 : ((nwr != 2'h0) ? cpu.be & {cpu.be != 2'h3, 1'b1} : 2'h0);
                    end
                end
                `CFA_OFS_READABLE_COUNT: begin
                    rdata_d                = `CFA_COUNT_RESET;
                    rdata_d[`CFA_VALID_BIT] = rd_ok;
                    rdata_d[`CFA_COUNT_W-1:0] = `CFA_COUNT_W'(avail);
                    lanes_d                = cpu.be;
                end
                `CFA_OFS_FREE_COUNT: begin
                    rdata_d                = `CFA_COUNT_RESET;
                    rdata_d[`CFA_COUNT_W-1:0] = `CFA_COUNT_W'(free);
                    lanes_d                = cpu.be;
                end
                `CFA_OFS_SINGLE_BYTE_READ: begin
                    if (!cpu.wr) begin
                        nrd          = take(2'h1, avail);
                        rdata_d[7:0] = (nrd != 2'h0) ? rb0 : 8'h00;
                        lanes_d      = {1'b0, nrd != 2'h0};
                    end
                end
                default: begin
                    rdata_d = 16'h0000;
                end
            endcase
        end
        // usb side: fill from staging fifo, drain to user
        fa       = fo_word[10:8];
        fa_ok    = fa < 3'(AREAS);
        fo_ready = fo_valid && fa_ok && !(wr_ok && fa == wa) && cnt_q[fa_ok ? fa : 3'h0] < (AW+1)'(DEPTH);
        fpush    = fo_ready;
        da_ok    = drain_area < 3'(AREAS) && !(rd_ok && drain_area == ra);
        da       = da_ok ? drain_area : 3'h0;
        drain_valid = da_ok && cnt_q[da] != '0;
        drain_data  = mem[idx(da, rp_q[da])];
        dpop        = drain_valid && drain_ready;
        for (int a = 0; a < AREAS; a++) begin
            push_n = 2'h0;
            pop_n  = 2'h0;
            if (wr_ok && wa == 3'(a)) begin
                push_n = nwr;
            end
            if (fpush && fa == 3'(a)) begin
                push_n = 2'h1;
            end
            if (rd_ok && ra == 3'(a)) begin
                pop_n = nrd;
            end
            if (dpop && da == 3'(a)) begin
                pop_n = 2'h1;
            end
            wp_d[a]  = wp_q[a] + AW'(push_n);
            rp_d[a]  = rp_q[a] + AW'(pop_n);
            cnt_d[a] = cnt_q[a] + (AW+1)'(push_n) - (AW+1)'(pop_n);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_q   <= 1'b0;
            rdata_q <= 16'h0000;
            lanes_q <= 2'h0;
            for (int a = 0; a < AREAS; a++) begin
                rp_q[a]  <= '0;
                wp_q[a]  <= '0;
                cnt_q[a] <= '0;
            end
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
            lanes_q <= lanes_d;
            rp_q    <= rp_d;
            wp_q    <= wp_d;
            cnt_q   <= cnt_d;
        end
    end

    // ==========================================================
    // byte storage
    always_ff @(posedge clk_sys) begin
        if (nwr != 2'h0) begin
            mem[idx(wa, wp_q[wa])] <= wb0;
        end
        if (nwr == 2'h2) begin
            mem[idx(wa, AW'(wp_q[wa] + 1'b1))] <= wb1;
        end
        if (fpush) begin
            mem[idx(fa, wp_q[fa])] <= fo_word[7:0];
        end
    end

    assign cpu.ack   = ack_q;
    assign cpu.rdata = rdata_q;
    assign cpu.lanes = lanes_q;
endmodule

//--- hdl/cfa_host.sv
/*
 * controller end of the cpu fifo port: takes commands over apb, checks
 * the count register first, then moves at most what the count allows.
 * assumes a zero wait apb master and the device answering with ack.
 */
`include "cfa_defs.svh"

module cfa_host (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    cfa_link.host            cpu
);
    cfa_pkg::host_state_t st_q, st_d;
    cfa_pkg::op_t         op_q, op_d;
    logic        req_q, req_d;
    logic        wr_q, wr_d;
    logic [7:0]  addr_q, addr_d;
    logic [1:0]  be_q, be_d;
    logic [15:0] wdata_q, wdata_d;
    logic [15:0] wreg_q, wreg_d;
    logic [18:0] res_q, res_d;
    logic [1:0]  mbe_q, mbe_d;
    logic        acc;
    logic [12:0] cnt;
    logic [1:0]  n;

    // ==========================================================
    // apb registers and command sequencer
    always_comb begin
        st_d    = st_q;
        op_d    = op_q;
        req_d   = 1'b0;
        wr_d    = wr_q;
        addr_d  = addr_q;
        be_d    = be_q;
        wdata_d = wdata_q;
        wreg_d  = wreg_q;
        res_d   = res_q;
        mbe_d   = mbe_q;
        acc     = psel && penable;
        pready  = 1'b1;
        pslverr = 1'b0;
        cnt     = cpu.rdata[`CFA_COUNT_W-1:0];
        n       = (cnt >= 13'h0002) ? 2'h2 : cnt[1:0];
        unique case (paddr)
            `CFA_APB_WDATA:  prdata = {16'h0000, wreg_q};
            `CFA_APB_RESULT: prdata = {13'h0000, res_q};
            `CFA_APB_STATUS: prdata = {31'h00000000, st_q != cfa_pkg::ST_IDLE};
            default:         prdata = 32'h00000000;
        endcase
        if (acc && pwrite && paddr == `CFA_APB_WDATA) begin
            wreg_d = pwdata[15:0];
        end
        unique case (st_q)
            cfa_pkg::ST_IDLE: begin
                if (acc && pwrite && paddr == `CFA_APB_CMD && pwdata[1:0] != 2'h0) begin
                    op_d = cfa_pkg::op_t'(pwdata[1:0]);
                    st_d = cfa_pkg::ST_CHECK;
                end
            end
            cfa_pkg::ST_CHECK: begin
                req_d  = 1'b1;
                wr_d   = 1'b0;
                be_d   = 2'h3;
                addr_d = (op_q == cfa_pkg::OP_WRITE) ? `CFA_OFS_FREE_COUNT : `CFA_OFS_READABLE_COUNT;
                st_d   = cfa_pkg::ST_CHECK_WAIT;
            end
            cfa_pkg::ST_CHECK_WAIT: begin
                if (cpu.ack) begin
                    if (op_q != cfa_pkg::OP_WRITE && !cpu.rdata[`CFA_VALID_BIT]) begin
                        n = 2'h0;
                    end
                    if (op_q == cfa_pkg::OP_BYTE && n != 2'h0) begin
                        n = 2'h1;
                    end
                    mbe_d = (n == 2'h2) ? 2'h3 : 2'h1;
                    if (n == 2'h0) begin
                        res_d = 19'h00000;
                        res_d[`CFA_RES_REFUSED_BIT] = 1'b1;
                        st_d  = cfa_pkg::ST_IDLE;
                    end else begin
                        st_d = cfa_pkg::ST_MOVE;
                    end
                end
            end
            cfa_pkg::ST_MOVE: begin
                req_d   = 1'b1;
                wr_d    = op_q == cfa_pkg::OP_WRITE;
                be_d    = mbe_q;
                wdata_d = wreg_q;
                unique case (op_q)
                    cfa_pkg::OP_WRITE: addr_d = `CFA_OFS_WRITE_LANE_LOW;
                    cfa_pkg::OP_BYTE:  addr_d = `CFA_OFS_SINGLE_BYTE_READ;
                    default:           addr_d = `CFA_OFS_READ_LANE_LOW;
                endcase
                st_d = cfa_pkg::ST_MOVE_WAIT;
            end
            cfa_pkg::ST_MOVE_WAIT: begin
                if (cpu.ack) begin
                    res_d = {1'b0, cpu.lanes, wr_q ? 16'h0000 : cpu.rdata};
                    st_d  = wr_q ? cfa_pkg::ST_SETTLE : cfa_pkg::ST_IDLE;
                end
            end
            cfa_pkg::ST_SETTLE: begin
                st_d = cfa_pkg::ST_IDLE;
            end
            default: begin
                st_d = cfa_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q    <= cfa_pkg::ST_IDLE;
            op_q    <= cfa_pkg::OP_NONE;
            req_q   <= 1'b0;
            wr_q    <= 1'b0;
            addr_q  <= 8'h00;
            be_q    <= 2'h0;
            wdata_q <= 16'h0000;
            wreg_q  <= 16'h0000;
            res_q   <= 19'h00000;
            mbe_q   <= 2'h0;
        end else begin
            st_q    <= st_d;
            op_q    <= op_d;
            req_q   <= req_d;
            wr_q    <= wr_d;
            addr_q  <= addr_d;
            be_q    <= be_d;
            wdata_q <= wdata_d;
            wreg_q  <= wreg_d;
            res_q   <= res_d;
            mbe_q   <= mbe_d;
        end
    end

    assign cpu.req   = req_q;
    assign cpu.wr    = wr_q;
    assign cpu.addr  = addr_q;
    assign cpu.be    = be_q;
    assign cpu.wdata = wdata_q;
endmodule

//--- test/cfa_link_asserts.sv
/*
 * checker for the cpu link between the fifo access port and its controller.
 * assumes one clk_sys domain and an active high asynchronous rst.
 */
module cfa_link_asserts (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        req,
    input wire logic        wr,
    input wire logic [7:0]  addr,
    input wire logic [1:0]  be,
    input wire logic        ack,
    input wire logic [15:0] rdata,
    input wire logic [1:0]  lanes
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ==========================================================
    // answer timing
    AST_ACK_AFTER_REQ: assert property (req |=> ack)
        else $error("ack missing one cycle after req");
    AST_NO_STRAY_ACK: assert property (ack |-> $past(req))
        else $error("ack without a request");
    AST_REQ_PULSE: assert property (req && wr |=> !req)
        else $error("request right after a write");

    // ==========================================================
    // count fields
    AST_RD_COUNT_FIELD: assert property (ack && !$past(wr) && $past(addr) == 8'h24 |->
        rdata[14:13] == 2'b00 && rdata[12:0] <= 13'd64)
        else $error("readable count field out of form");
    AST_FREE_COUNT_FIELD: assert property (ack && !$past(wr) && $past(addr) == 8'h26 |->
        rdata[15:13] == 3'b000 && rdata[12:0] <= 13'd64)
        else $error("free count field out of form");
    AST_COUNT_PAIR: assert property (req && !wr && (addr == 8'h24 || addr == 8'h26) |-> be == 2'b11)
        else $error("count read not as one pair");

    // ==========================================================
    // lanes
    AST_READ_LANES_IN_BE: assert property (ack && !$past(wr) && $past(addr) == 8'h20 |->
        (lanes & ~$past(be)) == 2'b00)
        else $error("read lane outside enables");
    AST_WRITE_LANES_IN_BE: assert property (ack && $past(wr) && $past(addr) == 8'h22 |->
        (lanes & ~$past(be)) == 2'b00)
        else $error("write lane outside enables");
    AST_BYTE_ONE_LANE: assert property (ack && !$past(wr) && $past(addr) == 8'h28 |-> !lanes[1])
        else $error("byte read used the high lane");

    // ==========================================================
    // host checks counts first
    AST_COUNT_BEFORE_DATA: assert property (req && !wr && (addr == 8'h20 || addr == 8'h28) |->
        $past(req, 3) && $past(addr, 3) == 8'h24)
        else $error("data read without count read");
    AST_FREE_BEFORE_WRITE: assert property (req && wr |-> $past(req, 3) && $past(addr, 3) == 8'h26)
        else $error("data write without free read");
endmodule

//--- test/tb.sv
/*
 * testbench: apb commands to the controller, fill and drain on the port.
 * assumes cfa_host and cfa_device joined by cfa_link on one clock.
 */
`include "cfa_defs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, res;
    logic [2:0]  rd_join, wr_join, fill_area, drain_area;
    logic        fill_valid, fill_ready, drain_valid, drain_ready;
    logic [7:0]  fill_data, drain_data;
    int          mismatches, cmp_count, acc;

    cfa_link link ();

    cfa_host cfa_host_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu(link));

    cfa_device cfa_device_inst (.clk_sys(clk_sys), .rst(rst), .cpu(link), .cpu_read_join_select(rd_join),
        .cpu_write_join_select(wr_join), .fill_valid(fill_valid), .fill_ready(fill_ready),
        .fill_area(fill_area), .fill_data(fill_data), .drain_area(drain_area), .drain_valid(drain_valid),
        .drain_ready(drain_ready), .drain_data(drain_data));

    cfa_link_asserts cfa_link_asserts_inst (.clk_sys(clk_sys), .rst(rst), .req(link.req), .wr(link.wr),
        .addr(link.addr), .be(link.be), .ack(link.ack), .rdata(link.rdata), .lanes(link.lanes));

    // ==========================================================
    // clock, checks, verdict
    always #5 clk_sys = ~clk_sys;

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // apb master
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task cmd(input cfa_pkg::op_t op, input logic [31:0] wd, output logic [31:0] r);
        logic [31:0] s;
        apb(1'b1, `CFA_APB_WDATA, wd, s);
        apb(1'b1, `CFA_APB_CMD, 32'(op), s);
        for (int i = 0; i < 60; i++) begin
            apb(1'b0, `CFA_APB_STATUS, 32'h0, s);
            if (s[0] === 1'b0) break;
        end
        chk("status idle", 32'h0, {31'h0, s[0]});
        apb(1'b0, `CFA_APB_RESULT, 32'h0, r);
    endtask

    // ==========================================================
    // fill and drain side
    task fill(input logic [2:0] a, input logic [7:0] d);
        fill_area <= a;
        fill_data <= d;
        fill_valid <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (fill_ready !== 1'b1);
        fill_valid <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    task drain_chk(input logic [2:0] a, input logic [7:0] exp[$]);
        int k;
        k = 0;
        drain_area <= a;
        drain_ready <= 1'b1;
        for (int i = 0; i < 60 && k < exp.size(); i++) begin
            @(posedge clk_sys);
            if (drain_valid) begin
                chk("drain byte", 32'(exp[k]), 32'(drain_data));
                k++;
            end
        end
        chk("drain count", exp.size(), k);
        drain_ready <= 1'b0;
    endtask

    task word_result(input string name, input logic [31:0] r, input logic [1:0] ln, input logic refused);
        chk(name, {ln, refused}, {r[`CFA_RES_LANES_LSB+:2], r[`CFA_RES_REFUSED_BIT]});
    endtask

    // ==========================================================
    // tests
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, fill_valid, drain_ready} = '0;
        paddr = '0;
        pwdata = '0;
        {rd_join, wr_join, fill_area, drain_area} = {3'd0, 3'd1, 3'd0, 3'd1};
        fill_data = '0;
        {mismatches, cmp_count} = '0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;

        apb(1'b0, `CFA_APB_RESULT, 32'h0, res);
        chk("result reset", 32'h0, res);
        apb(1'b0, 12'h010, 32'h0, res);
        chk("unmapped pslverr", 32'h0, {31'h0, pslverr});
        chk("unmapped read", 32'h0, res);
        cmd(cfa_pkg::OP_READ, 32'h0, res);
        chk("empty read refused", 32'h1, {31'h0, res[`CFA_RES_REFUSED_BIT]});
        $display("test reset_and_empty done");

        fill(3'd0, 8'hA1);
        fill(3'd0, 8'hA2);
        fill(3'd0, 8'hA3);
        cmd(cfa_pkg::OP_READ, 32'h0, res);
        chk("word read data", 32'hA2A1, {16'h0, res[15:0]});
        word_result("word read lanes", res, 2'b11, 1'b0);
        cmd(cfa_pkg::OP_READ, 32'h0, res);
        chk("fraction data", 32'hA3, {24'h0, res[7:0]});
        chk("fraction lanes", 32'h1, {30'h0, res[`CFA_RES_LANES_LSB+:2]});
        cmd(cfa_pkg::OP_READ, 32'h0, res);
        chk("drained read refused", 32'h1, {31'h0, res[`CFA_RES_REFUSED_BIT]});
        fill(3'd0, 8'h5C);
        cmd(cfa_pkg::OP_BYTE, 32'h0, res);
        chk("byte read data", 32'h5C, {24'h0, res[7:0]});
        chk("byte read lanes", 32'h1, {30'h0, res[`CFA_RES_LANES_LSB+:2]});
        $display("test read_port done");

        cmd(cfa_pkg::OP_WRITE, 32'hBEEF, res);
        word_result("word write", res, 2'b11, 1'b0);
        drain_chk(3'd1, '{8'hEF, 8'hBE});
        rd_join <= 3'd7;
        wr_join <= 3'd7;
        cmd(cfa_pkg::OP_READ, 32'h0, res);
        chk("no read join", 32'h1, {31'h0, res[`CFA_RES_REFUSED_BIT]});
        cmd(cfa_pkg::OP_WRITE, 32'h1234, res);
        chk("no write join", 32'h1, {31'h0, res[`CFA_RES_REFUSED_BIT]});
        $display("test write_and_join done");

        fill(3'd2, 8'h11);
        wr_join <= 3'd2;
        for (int i = 0; i < 31; i++) begin
            cmd(cfa_pkg::OP_WRITE, 32'hC3A5, res);
            word_result("fill word", res, 2'b11, 1'b0);
        end
        cmd(cfa_pkg::OP_WRITE, 32'hC3A5, res);
        chk("fraction write lanes", 32'h1, {30'h0, res[`CFA_RES_LANES_LSB+:2]});
        cmd(cfa_pkg::OP_WRITE, 32'hC3A5, res);
        chk("full write refused", 32'h1, {31'h0, res[`CFA_RES_REFUSED_BIT]});
        drain_chk(3'd2, '{8'h11, 8'hA5, 8'hC3});
        $display("test fraction_write done");

        wr_join <= 3'd3;
        acc = 0;
        fill_area <= 3'd3;
        fill_data <= 8'h50;
        fill_valid <= 1'b1;
        repeat (14) begin
            @(posedge clk_sys);
            if (fill_ready) begin
                acc++;
                fill_data <= 8'(8'h50 + acc);
            end
        end
        fill_valid <= 1'b0;
        chk("stage accepted", 32'd8, acc);
        wr_join <= 3'd7;
        repeat (30) @(posedge clk_sys);
        drain_chk(3'd3, '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57});
        @(posedge clk_sys);
        chk("area empty", 32'h0, {31'h0, drain_valid});
        $display("test stage_fifo done");
        print_verdict();
    end

    initial begin
        #500000;
        mismatches++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
